/* core/smc_map.svh */
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// ----------------------------------------------------------------------------
// reset values of the control bits
// ----------------------------------------------------------------------------
`define SMC_RST_IRQ_EN      1'h0
`define SMC_RST_MASTER_EN   1'h0
`define SMC_RST_PORT_EN     1'h0
`define SMC_RST_SEL_HI      1'h0
`define SMC_RST_SEL_LO      1'h1

// ----------------------------------------------------------------------------
// field positions inside the control word
// ----------------------------------------------------------------------------
`define SMC_CTRL_IRQ_EN_BIT 4
`define SMC_CTRL_MASTER_ENABLE_BIT  3
`define SMC_CTRL_PORTEN_BIT 2
`define SMC_CTRL_SEL_HI_BIT 1
`define SMC_CTRL_SEL_LO_BIT 0

// ----------------------------------------------------------------------------
// link timing: link clock cycles per serial bit and the last phase
// ----------------------------------------------------------------------------
`define SMC_PHASES_PER_BIT  4
`define SMC_PH_RISE         2'h1
`define SMC_PH_LAST         2'h3

`endif

/* core/smc_pkg.sv */
package smc_pkg;

    // link shift engine states
    typedef enum logic [1:0] {
        SMC_IDLE  = 2'b01,
        SMC_SHIFT = 2'b10
    } smc_state_t;

    // control word that software writes
    typedef struct packed {
        logic irq_enable;
        logic master_enable;
        logic port_enable;
        logic select_mode_hi;
        logic select_mode_lo;
    } smc_ctrl_t;

    // flag clear strobes
    typedef struct packed {
        logic done_clr;
        logic fault_clr;
    } smc_clr_t;

    // status seen by software
    typedef struct packed {
        logic busy;
        logic transfer_done_flag;
        logic mode_fault_flag;
    } smc_stat_t;

endpackage

/* core/smc_sync.sv */
`timescale 1ns/1ps

// two-flop level synchroniser; the first stage feeds only the second
module smc_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end

endmodule // smc_sync

/* core/smc_master.sv */
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_master #(
    parameter int W = 8
) (
    // system clock domain
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // link clock
    input  wire logic              link_clk,
    // software side
    input  wire logic              ctrl_wr,
    input  wire smc_pkg::smc_ctrl_t ctrl_wdata,
    input  wire smc_pkg::smc_clr_t flag_clr,
    input  wire logic              data_wr,
    input  wire logic [W-1:0]      data_wdata,
    output smc_pkg::smc_ctrl_t     ctrl_q,
    output smc_pkg::smc_stat_t     stat_q,
    output logic [W-1:0]           rx_data,
    output logic                   irq_req,
    // serial pins
    output logic                   sck,
    output logic                   mosi,
    input  wire logic              miso,
    input  wire logic              slave_select_n_in,
    output logic                   slave_select_n_out,
    output logic                   slave_select_n_oe
);

    // ------------------------------------------------------------------------
    // system clock domain state
    // ------------------------------------------------------------------------
    smc_pkg::smc_ctrl_t ctrl_r;
    logic               done_r;
    logic               fault_r;
    logic               busy_r;
    logic               irq_r;
    logic [W-1:0]       rx_buf_r;
    logic [W-1:0]       tx_hold_r;
    logic               start_tgl_r;
    logic               done_seen_r;
    logic               nss_out_r;
    logic               nss_oe_r;

    // link domain state
    smc_pkg::smc_state_t state_r;
    logic [1:0]          ph_r;
    logic [$clog2(W)-1:0] bit_cnt_r;
    logic [W-1:0]        shift_r;
    logic [W-1:0]        rx_l_r;
    logic                start_seen_r;
    logic                done_tgl_r;
    logic                sck_r;
    logic                mosi_r;

    // synchronised views
    logic               done_tgl_s;
    logic               nss_s;
    logic               rst_l;
    logic               ce_l;
    logic               start_tgl_s;
    logic               miso_s;

    // ------------------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------------------
    smc_sync #(.W(2)) u_sync_sys (
        .clk (clk),
        .d   ({done_tgl_r, slave_select_n_in}),
        .q   ({done_tgl_s, nss_s})
    );

    smc_sync #(.W(4)) u_sync_link (
        .clk (link_clk),
        .d   ({rst, ce, start_tgl_r, miso}),
        .q   ({rst_l, ce_l, start_tgl_s, miso_s})
    );

    // ------------------------------------------------------------------------
    // system side decode
    // ------------------------------------------------------------------------
    wire mode_multi = !ctrl_r.select_mode_hi && ctrl_r.select_mode_lo;
    wire mode_three = !ctrl_r.select_mode_hi && !ctrl_r.select_mode_lo;
    wire mode_four  = ctrl_r.select_mode_hi;
    wire enabled    = ctrl_r.master_enable && ctrl_r.port_enable;
    // another master pulled select low while we own the bus
    wire fault_evt  = mode_multi && ctrl_r.port_enable && !nss_s;
    wire done_evt   = done_tgl_s != done_seen_r;
    wire start_ok   = data_wr && enabled && !busy_r;
    wire done_nxt   = done_evt || (done_r && !flag_clr.done_clr);
    wire fault_nxt  = fault_evt || (fault_r && !flag_clr.fault_clr);
    wire irq_nxt    = ctrl_r.irq_enable && (done_r || fault_r);

    smc_pkg::smc_ctrl_t ctrl_nxt;
    always_comb begin
        ctrl_nxt = ctrl_wr ? ctrl_wdata : ctrl_r;
        // the fault wins over a same-cycle write; software re-enables later
        if (fault_evt) begin
            ctrl_nxt.master_enable = 1'h0;
            ctrl_nxt.port_enable   = 1'h0;
        end
    end

    // ------------------------------------------------------------------------
    // system side registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r.irq_enable     <= `SMC_RST_IRQ_EN;
            ctrl_r.master_enable  <= `SMC_RST_MASTER_EN;
            ctrl_r.port_enable    <= `SMC_RST_PORT_EN;
            ctrl_r.select_mode_hi <= `SMC_RST_SEL_HI;
            ctrl_r.select_mode_lo <= `SMC_RST_SEL_LO;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_r  <= 1'h0;
            fault_r <= 1'h0;
            irq_r   <= 1'h0;
        end else if (ce) begin
            done_r  <= done_nxt;
            fault_r <= fault_nxt;
            irq_r   <= irq_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r      <= 1'h0;
            start_tgl_r <= 1'h0;
            done_seen_r <= 1'h0;
            tx_hold_r   <= '0;
        end else if (ce) begin
            if (start_ok) begin
                busy_r      <= 1'h1;
                start_tgl_r <= !start_tgl_r;
                tx_hold_r   <= data_wdata;
            end else if (done_evt) begin
                busy_r      <= 1'h0;
            end
            done_seen_r <= done_tgl_s;
        end
    end

    // receive buffer: the link word is stable until the next start
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buf_r <= '0;
        end else if (ce && done_evt) begin
            rx_buf_r <= rx_l_r;
        end
    end

    // select pin: undriven in 3-wire and multi-master, follows lo in 4-wire
    always_ff @(posedge clk) begin
        if (rst) begin
            nss_out_r <= 1'h1;
            nss_oe_r  <= 1'h0;
        end else if (ce) begin
            nss_oe_r  <= ctrl_nxt.select_mode_hi;
            nss_out_r <= ctrl_nxt.select_mode_hi ? ctrl_nxt.select_mode_lo : 1'h1;
        end
    end

    // ------------------------------------------------------------------------
    // link side shift engine
    // ------------------------------------------------------------------------
    wire          start_req = start_tgl_s != start_seen_r;
    wire          bit_end   = (state_r == smc_pkg::SMC_SHIFT) && (ph_r == `SMC_PH_LAST);
    wire          last_bit  = bit_cnt_r == ($clog2(W))'(W - 1);
    // miso is two link cycles late, so the sample lands at the rising edge
    wire [W-1:0]  shift_nxt = {shift_r[W-2:0], miso_s};

    always_ff @(posedge link_clk) begin
        if (rst_l) begin
            state_r      <= smc_pkg::SMC_IDLE;
            ph_r         <= 2'h0;
            bit_cnt_r    <= '0;
            start_seen_r <= 1'h0;
        end else if (ce_l) begin
            unique case (state_r)
                smc_pkg::SMC_IDLE: begin
                    if (start_req) begin
                        state_r      <= smc_pkg::SMC_SHIFT;
                        start_seen_r <= start_tgl_s;
                        ph_r         <= 2'h0;
                        bit_cnt_r    <= '0;
                    end
                end
                smc_pkg::SMC_SHIFT: begin
                    ph_r <= ph_r + 2'h1;
                    if (bit_end) begin
                        bit_cnt_r <= bit_cnt_r + ($clog2(W))'(1);
                        if (last_bit) begin
                            state_r <= smc_pkg::SMC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (rst_l) begin
            shift_r    <= '0;
            rx_l_r     <= '0;
            done_tgl_r <= 1'h0;
            mosi_r     <= 1'h0;
            sck_r      <= 1'h0;
        end else if (ce_l) begin
            if (state_r == smc_pkg::SMC_IDLE && start_req) begin
                shift_r <= tx_hold_r;
                mosi_r  <= tx_hold_r[W-1];
            end else if (bit_end) begin
                shift_r <= shift_nxt;
                mosi_r  <= shift_nxt[W-1];
                if (last_bit) begin
                    rx_l_r     <= shift_nxt;
                    done_tgl_r <= !done_tgl_r;
                end
            end
            sck_r <= (state_r == smc_pkg::SMC_SHIFT) && (ph_r == `SMC_PH_RISE
                     || ph_r == 2'h2);
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign ctrl_q             = ctrl_r;
    assign stat_q             = '{busy: busy_r, transfer_done_flag: done_r,
                                  mode_fault_flag: fault_r};
    assign rx_data            = rx_buf_r;
    assign irq_req            = irq_r;
    assign sck                = sck_r;
    assign mosi               = mosi_r;
    assign slave_select_n_out = nss_out_r;
    assign slave_select_n_oe  = nss_oe_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_done_sets_flag: assert property (@(posedge clk) disable iff (rst)
        (ce && done_evt) |=> done_r)
        else $error("done flag did not set after transfer end");

    a_done_irq_raise: assert property (@(posedge clk) disable iff (rst)
        (ce && done_r && ctrl_r.irq_enable) |=> irq_r)
        else $error("irq missing for done flag");

    a_rx_buffer_load: assert property (@(posedge clk) disable iff (rst)
        (ce && done_evt) |=> rx_buf_r == $past(rx_l_r))
        else $error("receive buffer not loaded");

    a_fault_disables: assert property (@(posedge clk) disable iff (rst)
        (ce && fault_evt) |=> (!ctrl_r.master_enable && !ctrl_r.port_enable && fault_r))
        else $error("mode fault did not disable the port");

    a_fault_irq_raise: assert property (@(posedge clk) disable iff (rst)
        (ce && fault_r && ctrl_r.irq_enable) |=> irq_r)
        else $error("irq missing for mode fault");

    a_reset_multi_mode: assert property (@(posedge clk)
        rst |=> (!ctrl_r.select_mode_hi && ctrl_r.select_mode_lo))
        else $error("reset did not select multi-master mode");

    a_three_wire_idle: assert property (@(posedge clk) disable iff (rst)
        (ce && !ctrl_wr && mode_three) |=> !nss_oe_r)
        else $error("select pin driven in 3-wire mode");

    a_multi_pin_input: assert property (@(posedge clk) disable iff (rst)
        (ce && !ctrl_wr && mode_multi) |=> !nss_oe_r)
        else $error("select pin driven in multi-master mode");

    a_four_wire_level: assert property (@(posedge clk) disable iff (rst)
        (ce && !ctrl_wr && mode_four) |=> (nss_oe_r && nss_out_r == $past(ctrl_r.select_mode_lo)))
        else $error("select output does not follow select_mode_lo");

    a_start_sets_busy: assert property (@(posedge clk) disable iff (rst)
        (ce && start_ok) |=> busy_r)
        else $error("accepted write did not start a transfer");

    a_msb_first_shift: assert property (@(posedge link_clk) disable iff (rst_l)
        (ce_l && bit_end) |=> (shift_r[0] == $past(miso_s) && mosi_r == shift_r[W-1]))
        else $error("shift register not msb first");

    a_eight_bit_times: assert property (@(posedge link_clk) disable iff (rst_l)
        (ce_l && bit_end && last_bit) |=> (state_r == smc_pkg::SMC_IDLE))
        else $error("transfer did not end after the last bit");

    a_done_ends_busy: assert property (@(posedge clk) disable iff (rst)
        (ce && done_evt) |=> !busy_r)
        else $error("busy still set after the done flag");

    a_busy_write_refused: assert property (@(posedge clk) disable iff (rst)
        (ce && data_wr && busy_r) |=> $stable(tx_hold_r))
        else $error("write while busy changed the transmit byte");

    // helper: serial clock rises in the current frame, so the bit count is not
    // checked against the same counter that ends the frame
    logic [$clog2(W):0] sck_rises_r;
    logic               sck_d_r;

    always_ff @(posedge link_clk) begin
        if (rst_l) begin
            sck_rises_r <= '0;
            sck_d_r     <= 1'h0;
        end else if (ce_l) begin
            sck_d_r <= sck_r;
            if (state_r == smc_pkg::SMC_IDLE && start_req) begin
                sck_rises_r <= '0;
            end else if (sck_r && !sck_d_r) begin
                sck_rises_r <= sck_rises_r + ($clog2(W)+1)'(1);
            end
        end
    end

    a_eight_sck_rises: assert property (@(posedge link_clk) disable iff (rst_l)
        (ce_l && bit_end && last_bit) |-> sck_rises_r == ($clog2(W)+1)'(W))
        else $error("frame did not carry one serial clock per bit");

    c_transfer_done: cover property (@(posedge clk) disable iff (rst) ce && done_evt);
    c_mode_fault: cover property (@(posedge clk) disable iff (rst) ce && fault_evt);
    c_four_wire_low: cover property (@(posedge clk) disable iff (rst)
        nss_oe_r && !nss_out_r);
    c_three_wire_done: cover property (@(posedge clk) disable iff (rst)
        ce && done_evt && mode_three);
    c_write_refused: cover property (@(posedge clk) disable iff (rst) ce && data_wr && busy_r);

endmodule // smc_master

/* tb/smc_slave_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// single serial slave; further slaves would hang off general pins, not here
// ----------------------------------------------------------------------------
module smc_slave_model (
    // serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // bench side
    input  wire logic       active,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte,
    output logic [3:0]      n_bits
);
    logic [7:0] sh;

    initial begin
        miso    = 1'h0;
        sh      = 8'h00;
        rx_byte = 8'h00;
        n_bits  = 4'h0;
    end

    // first bit stands well before the first rising sck edge
    always @(posedge active) begin
        sh      = tx_byte;
        n_bits  = 4'h0;
        rx_byte = 8'h00;
        miso    = tx_byte[7];
    end

    always @(posedge sck) begin
        if (active) begin
            rx_byte = {rx_byte[6:0], mosi};
            n_bits  = n_bits + 4'h1;
        end
    end

    // next bit after the falling edge, held through the following high phase
    always @(negedge sck) begin
        if (active) begin
            sh   = {sh[6:0], ~sh[0]};
            miso = sh[7];
        end
    end

    // a released line does not keep its last level
    always @(negedge active) miso = ~miso;
endmodule // smc_slave_model

/* tb/smc_master_tb.sv */
`timescale 1ns/1ps

module smc_master_tb;
    logic               clk;
    logic               link_clk;
    logic               rst;
    logic               ce;
    logic               ctrl_wr;
    logic               data_wr;
    logic               miso;
    logic               ss_ext;
    logic               sl_active;
    logic               irq_req;
    logic               sck;
    logic               mosi;
    logic               ss_out;
    logic               ss_oe;
    smc_pkg::smc_ctrl_t ctrl_wdata;
    smc_pkg::smc_ctrl_t ctrl_q;
    smc_pkg::smc_clr_t  flag_clr;
    smc_pkg::smc_stat_t stat_q;
    logic [7:0]         data_wdata;
    logic [7:0]         rx_data;
    logic [7:0]         sl_tx;
    logic [7:0]         sl_rx;
    logic [3:0]         sl_bits;
    wire                ss_wire = ss_oe ? ss_out : ss_ext;
    int                 n_errors = 0;
    int                 n_tests = 0;

    smc_master u_smc_master (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .flag_clr(flag_clr),
        .data_wr(data_wr), .data_wdata(data_wdata), .ctrl_q(ctrl_q), .stat_q(stat_q),
        .rx_data(rx_data), .irq_req(irq_req), .sck(sck), .mosi(mosi), .miso(miso),
        .slave_select_n_in(ss_wire), .slave_select_n_out(ss_out),
        .slave_select_n_oe(ss_oe));

    smc_slave_model u_smc_slave_model (.sck(sck), .mosi(mosi), .miso(miso),
        .active(sl_active), .tx_byte(sl_tx), .rx_byte(sl_rx), .n_bits(sl_bits));

    // ------------------------------------------------------------------------
    // clocks
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 1'h0;
        #3.7;
        forever #40 link_clk = ~link_clk;
    end

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_ctrl(input logic [4:0] v);
        @(posedge clk);
        ctrl_wr    <= 1'h1;
        ctrl_wdata <= smc_pkg::smc_ctrl_t'(v);
        @(posedge clk);
        ctrl_wr    <= 1'h0;
        @(negedge clk);
    endtask

    task automatic wr_data(input logic [7:0] b);
        @(posedge clk);
        data_wr    <= 1'h1;
        data_wdata <= b;
        @(posedge clk);
        data_wr    <= 1'h0;
        @(negedge clk);
    endtask

    // clear strobe, then one more cycle so irq_req has followed the flags
    task automatic clr(input logic [1:0] v);
        @(posedge clk);
        flag_clr <= smc_pkg::smc_clr_t'(v);
        @(posedge clk);
        flag_clr <= 2'h0;
        @(negedge clk);
        @(negedge clk);
    endtask

    // sel 1 waits for the fault flag, sel 0 for the done flag
    task automatic wait_flag(input logic sel);
        int i;
        for (i = 0; i < 1000; i++) begin
            if ((sel ? stat_q.mode_fault_flag : stat_q.transfer_done_flag) === 1'h1) break;
            @(negedge clk);
        end
        if (i == 1000) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, 1'h0, 1'h1);
            final_report();
        end
    endtask

    // one byte each way; poke adds a write while busy that must be ignored
    task automatic xfer(input logic [7:0] tx, input logic [7:0] sl, input logic poke,
                        input logic irq);
        @(posedge clk);
        sl_tx     <= sl;
        sl_active <= 1'h1;
        wr_data(tx);
        chk(stat_q.busy, 8'h01);
        if (poke) wr_data(~tx);
        wait_flag(1'h0);
        chk(stat_q.busy, 8'h00);
        chk(rx_data, sl);
        chk(sl_rx, tx);
        chk(sl_bits, 8'h08);
        @(negedge clk);
        chk(irq_req, irq);
        repeat (20) @(negedge clk);
        chk(stat_q.busy, 8'h00);
        chk(sck, 8'h00);
        @(posedge clk);
        sl_active <= 1'h0;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        chk(ctrl_q, 8'h01);
        chk(stat_q, 8'h00);
        chk(irq_req, 8'h00);
        chk(ss_oe, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_modes;
        logic [1:0] m;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr_ctrl({3'h0, m});
            chk(ss_oe, m[1]);
            chk(ss_out, m[1] ? m[0] : 1'h1);
        end
        $display("test modes done");
    endtask

    task automatic t_xfer4;
        wr_ctrl(5'h1e);
        chk(ss_wire, 8'h00);
        xfer(8'ha5, 8'h3c, 1'h1, 1'h1);
        clr(2'h2);
        chk(stat_q, 8'h00);
        chk(irq_req, 8'h00);
        xfer(8'h01, 8'h80, 1'h0, 1'h1);
        clr(2'h2);
        $display("test four wire done");
    endtask

    task automatic t_fault;
        // drive select high first so the synchroniser holds no stale low
        wr_ctrl(5'h03);
        wr_ctrl(5'h1d);
        repeat (3) @(negedge clk);
        chk(stat_q.mode_fault_flag, 8'h00);
        @(posedge clk);
        ss_ext <= 1'h0;
        wait_flag(1'h1);
        chk(ctrl_q.master_enable, 8'h00);
        chk(ctrl_q.port_enable, 8'h00);
        @(negedge clk);
        chk(irq_req, 8'h01);
        wr_data(8'h55);
        chk(stat_q.busy, 8'h00);
        @(posedge clk);
        ss_ext <= 1'h1;
        clr(2'h1);
        chk(stat_q, 8'h00);
        chk(irq_req, 8'h00);
        chk(ctrl_q, 8'h11);
        wr_ctrl(5'h1c);
        @(posedge clk);
        ss_ext <= 1'h0;
        xfer(8'hc3, 8'h5a, 1'h0, 1'h1);
        chk(stat_q.mode_fault_flag, 8'h00);
        @(posedge clk);
        ss_ext <= 1'h1;
        clr(2'h3);
        $display("test mode fault done");
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst        = 1'h1;
        ce         = 1'h1;
        ctrl_wr    = 1'h0;
        ctrl_wdata = smc_pkg::smc_ctrl_t'(5'h01);
        flag_clr   = 2'h0;
        data_wr    = 1'h0;
        data_wdata = 8'h00;
        ss_ext     = 1'h1;
        sl_active  = 1'h0;
        sl_tx      = 8'h00;
        // long enough for the reset to reach the link side as well
        repeat (40) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        t_reset();
        t_modes();
        t_xfer4();
        t_fault();
        final_report();
    end
endmodule // smc_master_tb
